// *** shared/olm_pkg.sv ***
// Constants, types and encodings for the OR, load and move instruction unit
package olm_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	// Opcode field patterns
	localparam logic [7:0] OP_OR_LIT   = 8'h09;
	localparam logic [5:0] OP_OR_FILE  = 6'h04;
	localparam logic [5:0] OP_MOV_FILE = 6'h14;
	localparam logic [5:0] OP_LD_PTR   = 6'h38;
	localparam logic [7:0] OP_LD_PTR2  = 8'hf0;
	localparam logic [3:0] OP_MOVFF1   = 4'hc;
	localparam logic [3:0] OP_SECOND   = 4'hf;
	// Field positions
	localparam int D_BIT = 9;
	localparam int A_BIT = 8;
	localparam int PSEL_HI = 9;
	localparam int PSEL_LO = 8;
	// Access bank split: low half maps to 0x000, high half to 0xf00
	localparam logic [7:0] ACC_SPLIT  = 8'h80;
	localparam logic [3:0] ACC_HI_BNK = 4'hf;
	localparam logic [3:0] ACC_LO_BNK = 4'h0;
	// Accumulator data address, for the two-word move
	localparam logic [11:0] ACC_ADDR = 12'hfe8;
	localparam logic [1:0]  PTR_MAX  = 2'h2;
	localparam logic [1:0]  PH_RD    = 2'h1;
	localparam logic [1:0]  PH_WR    = 2'h3;

	typedef struct packed {
		logic        valid;
		logic [15:0] word;
	} olm_instr_t;

	typedef struct packed {
		logic                 rdEn;
		logic                 wrEn;
		logic [ADDR_W-1:0]    addr;
		logic [DATA_W-1:0]    wdata;
	} olm_mem_t;

	typedef struct packed {
		logic       wrHigh;
		logic       wrLow;
		logic [1:0] sel;
		logic [7:0] data;
	} olm_ptr_t;

	typedef enum logic [1:0] {OLM_OPEN, OLM_PTR2, OLM_MOV2} olm_state_t;
endpackage

// *** hdl/olm_phase_ctr.sv ***
// Four-phase cycle counter of the core
`timescale 1ns/100ps
module olm_phase_ctr (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Phase
	output logic [1:0]      phase,
	output logic            lastPhase
);
	logic [1:0] phase_r;

	always_ff @(posedge clk) begin
		if (srst) phase_r <= 2'h0;
		else phase_r <= phase_r + 2'h1;
	end

	assign phase = phase_r;
	assign lastPhase = (phase_r == 2'h3);
endmodule // olm_phase_ctr

// *** hdl/olm_exec.sv ***
// Decode and execute of OR, pointer load and move instructions
`timescale 1ns/100ps
module olm_exec
	import olm_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// Instruction word, held for a whole cycle
	input  wire olm_pkg::olm_instr_t      instr,
	// Core context
	input  wire logic [3:0]               bankSel,
	input  wire logic [7:0]               memRdata,
	// Data memory request
	output olm_pkg::olm_mem_t             mem,
	// Pointer register writes
	output olm_pkg::olm_ptr_t             ptr,
	// Accumulator and flags
	output logic [7:0]                    acc,
	output logic                          flagN,
	output logic                          flagZ,
	// Phase of the instruction cycle
	output logic [1:0]                    phaseOut,
	output logic                          cycleDone
);
	import olm_pkg::*;

	logic [1:0]  phase;
	logic        lastPhase;
	olm_state_t  state_r, state_nxt;
	logic [7:0]  acc_r, acc_nxt;
	logic        flagN_r, flagN_nxt;
	logic        flagZ_r, flagZ_nxt;
	olm_mem_t    mem_r, mem_nxt;
	olm_ptr_t    ptr_r, ptr_nxt;
	logic [7:0]  hold_r, hold_nxt;
	logic [1:0]  ptrSel_r, ptrSel_nxt;
	logic [1:0]  phase_r;
	logic        done_r;

	olm_phase_ctr u_phase (
		.clk       (clk),
		.srst      (srst),
		.phase     (phase),
		.lastPhase (lastPhase)
	);

	// Decode
	wire [15:0] w        = instr.word;
	wire        isOrLit  = (state_r == OLM_OPEN) && (w[15:8] == OP_OR_LIT);
	wire        isOrFile = (state_r == OLM_OPEN) && (w[15:10] == OP_OR_FILE);
	wire        isMovF   = (state_r == OLM_OPEN) && (w[15:10] == OP_MOV_FILE);
	wire        isLdPtr  = (state_r == OLM_OPEN) && (w[15:10] == OP_LD_PTR)
		&& (w[PSEL_HI:PSEL_LO] <= PTR_MAX);
	wire        isMovFF  = (state_r == OLM_OPEN) && (w[15:12] == OP_MOVFF1);
	wire        isFile   = isOrFile || isMovF;
	wire        destFile = w[D_BIT];
	// Access bank or banked address
	wire [3:0]  accBank  = (w[7:0] < ACC_SPLIT) ? ACC_LO_BNK : ACC_HI_BNK;
	wire [11:0] fileAddr = w[A_BIT] ? {bankSel, w[7:0]} : {accBank, w[7:0]};
	// Accumulator as a move operand
	wire        srcIsAcc = (w[11:0] == ACC_ADDR);
	wire [7:0]  rdVal    = srcIsAcc ? acc_r : memRdata;
	wire [7:0]  orLit    = acc_r | w[7:0];
	wire [7:0]  orFile   = acc_r | memRdata;
	wire [7:0]  fileRes  = isOrFile ? orFile : memRdata;
	wire        ph1      = (phase == PH_RD);

	always_comb begin
		state_nxt  = state_r;
		acc_nxt    = acc_r;
		flagN_nxt  = flagN_r;
		flagZ_nxt  = flagZ_r;
		hold_nxt   = hold_r;
		ptrSel_nxt = ptrSel_r;
		mem_nxt    = '0;
		ptr_nxt    = '0;
		if (instr.valid) begin
			if (isFile && ph1) begin
				// Read in phase two
				mem_nxt.rdEn = 1'b1;
				mem_nxt.addr = fileAddr;
			end
			if (isMovFF && ph1) begin
				// Source read in the first cycle
				mem_nxt.rdEn = !srcIsAcc;
				mem_nxt.addr = w[11:0];
			end
			if (lastPhase) begin
				unique case (state_r)
					OLM_OPEN: begin
						if (isOrLit) begin
							acc_nxt   = orLit;
							flagN_nxt = orLit[7];
							flagZ_nxt = (orLit == 8'h00);
						end else if (isFile) begin
							// Write destination in phase four
							flagN_nxt = fileRes[7];
							flagZ_nxt = (fileRes == 8'h00);
							if (destFile) begin
								mem_nxt.wrEn  = 1'b1;
								mem_nxt.addr  = fileAddr;
								mem_nxt.wdata = fileRes;
							end else begin
								acc_nxt = fileRes;
							end
						end else if (isLdPtr) begin
							// High byte first, flags untouched
							ptr_nxt.wrHigh = 1'b1;
							ptr_nxt.sel    = w[PSEL_HI:PSEL_LO];
							ptr_nxt.data   = {4'h0, w[3:0]};
							ptrSel_nxt     = w[PSEL_HI:PSEL_LO];
							state_nxt      = OLM_PTR2;
						end else if (isMovFF) begin
							hold_nxt  = rdVal;
							state_nxt = OLM_MOV2;
						end
						// Lone 1111 word falls through as no-operation
					end
					OLM_PTR2: begin
						ptr_nxt.wrLow = 1'b1;
						ptr_nxt.sel   = ptrSel_r;
						ptr_nxt.data  = w[7:0];
						state_nxt     = OLM_OPEN;
					end
					OLM_MOV2: begin
						// No dummy read, write at the end
						if (w[11:0] == ACC_ADDR) begin
							acc_nxt = hold_r;
						end else begin
							mem_nxt.wrEn  = 1'b1;
							mem_nxt.addr  = w[11:0];
							mem_nxt.wdata = hold_r;
						end
						state_nxt = OLM_OPEN;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r  <= OLM_OPEN;
			acc_r    <= 8'h00;
			flagN_r  <= 1'b0;
			flagZ_r  <= 1'b0;
			mem_r    <= '0;
			ptr_r    <= '0;
			hold_r   <= 8'h00;
			ptrSel_r <= 2'h0;
			phase_r  <= 2'h0;
			done_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			acc_r    <= acc_nxt;
			flagN_r  <= flagN_nxt;
			flagZ_r  <= flagZ_nxt;
			mem_r    <= mem_nxt;
			ptr_r    <= ptr_nxt;
			hold_r   <= hold_nxt;
			ptrSel_r <= ptrSel_nxt;
			phase_r  <= phase;
			done_r   <= lastPhase;
		end
	end

	assign mem       = mem_r;
	assign ptr       = ptr_r;
	assign acc       = acc_r;
	assign flagN     = flagN_r;
	assign flagZ     = flagZ_r;
	assign phaseOut  = phase_r;
	assign cycleDone = done_r;
endmodule // olm_exec

// *** verification/olm_mem_model.sv ***
// Data memory model on the far side of the unit
`timescale 1ns/100ps
module olm_mem_model (
	// Clock
	input  wire logic              clk,
	// Memory request and answer
	input  wire olm_pkg::olm_mem_t mem,
	output logic [7:0]             memRdata
);
	import olm_pkg::*;
	logic [7:0] arr [4096];
	initial begin
		memRdata = 8'h00;
		for (int i = 0; i < 4096; i++) arr[i] = 8'(i * 37);
	end
	// Data valid one clock after the read, then scrambled
	always @(posedge clk) begin
		memRdata <= mem.rdEn ? arr[mem.addr] : ~memRdata;
		if (mem.wrEn) arr[mem.addr] <= mem.wdata;
	end
endmodule // olm_mem_model

// *** verification/olm_exec_props.sv ***
// Port assertions of the instruction unit
`timescale 1ns/100ps
module olm_exec_props (
	// Design ports
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire olm_pkg::olm_instr_t instr,
	input  wire logic [3:0]          bankSel,
	input  wire logic [7:0]          memRdata,
	input  wire olm_pkg::olm_mem_t   mem,
	input  wire olm_pkg::olm_ptr_t   ptr,
	input  wire logic [7:0]          acc,
	input  wire logic                flagN,
	input  wire logic                flagZ,
	input  wire logic [1:0]          phaseOut,
	input  wire logic                cycleDone
);
	import olm_pkg::*;
	logic [15:0] prevWord_r;
	wire  [5:0]  op = instr.word[15:10];
	wire         fl = op == OP_OR_FILE || op == OP_MOV_FILE;
	wire         pf = prevWord_r[15:10] inside {OP_OR_FILE, OP_MOV_FILE};
	wire  [7:0]  f  = instr.word[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	always_ff @(posedge clk) prevWord_r <= instr.word;
	property p_orLit;
		cycleDone && prevWord_r[15:8] == OP_OR_LIT |->
		acc == ($past(acc) | prevWord_r[7:0]) && flagN == acc[7];
	endproperty
	a_orLit: assert property (p_orLit) else $error("or literal bad");
	property p_fileDst;
		cycleDone && pf |-> mem.wrEn == prevWord_r[D_BIT] &&
		flagZ == ((prevWord_r[D_BIT] ? mem.wdata : acc) == 8'h00);
	endproperty
	a_fileDst: assert property (p_fileDst) else $error("dest bad");
	property p_bank;
		mem.rdEn && fl |-> mem.addr == (instr.word[A_BIT] ? {bankSel, f}
		: {f[7] ? ACC_HI_BNK : ACC_LO_BNK, f});
	endproperty
	a_bank: assert property (p_bank) else $error("bank bad");
	property p_phase;
		mem.rdEn |-> phaseOut == PH_RD ##2 cycleDone;
	endproperty
	a_phase: assert property (p_phase) else $error("read phase bad");
	property p_ptrDat;
		ptr.wrHigh || ptr.wrLow |-> cycleDone && $stable(flagZ) && ptr.data ==
		(ptr.wrHigh ? {4'h0, prevWord_r[3:0]} : prevWord_r[7:0]);
	endproperty
	a_ptrDat: assert property (p_ptrDat) else $error("ptr data bad");
	property p_ptrSeq;
		ptr.wrHigh |-> ##4 ptr.wrLow && ptr.sel == $past(ptr.sel, 4);
	endproperty
	a_ptrSeq: assert property (p_ptrSeq) else $error("ptr order bad");
	property p_mvRd;
		cycleDone && prevWord_r[15:12] == OP_MOVFF1 &&
		prevWord_r[11:0] != ACC_ADDR |-> !mem.wrEn && $past(mem.rdEn, 2) &&
		$past(mem.addr, 2) == prevWord_r[11:0];
	endproperty
	a_mvRd: assert property (p_mvRd) else $error("move read bad");
	property p_second;
		cycleDone && prevWord_r[15:12] == OP_SECOND |->
		$stable(flagN) && $stable(flagZ);
	endproperty
	a_second: assert property (p_second) else $error("flags moved");
endmodule // olm_exec_props
bind olm_exec olm_exec_props props_u (.clk, .srst, .instr, .bankSel,
	.memRdata, .mem, .ptr, .acc, .flagN, .flagZ, .phaseOut, .cycleDone);

// *** verification/tb_or_load_move_instr_exec.sv ***
// Self-checking bench of the instruction unit
`timescale 1ns/100ps
module tb_or_load_move_instr_exec;
	import olm_pkg::*;
	logic        clk = 0, srst = 1, flagN, flagZ, cycleDone, eN = 0, eZ = 0;
	logic [3:0]  bankSel = 4'h0;
	logic [7:0]  memRdata, acc, eAcc = 0, m [4096];
	logic [1:0]  phaseOut;
	logic [31:0] rng = 32'hfdc6;
	logic [21:0] eW = 0, eP = 0;
	logic [15:0] pend = 0;
	olm_instr_t  instr = '0;
	olm_mem_t    mem;
	olm_ptr_t    ptr;
	int          n_errors = 0, checked = 0;
	olm_exec dut_u (.clk, .srst, .instr, .bankSel, .memRdata, .mem, .ptr,
		.acc, .flagN, .flagZ, .phaseOut, .cycleDone);
	olm_mem_model mem_u (.clk, .mem, .memRdata);
	always #5 clk = ~clk;
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic cmp(logic [21:0] got, logic [21:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Present word at the phase 3 edge, check the finished cycle
	task automatic step(logic [15:0] w);
		logic [7:0]  r;
		logic [11:0] a;
		repeat (9) if (phaseOut !== 2'h2) @(negedge clk);
		@(posedge clk);
		instr   <= '{1'b1, w};
		bankSel <= rng[31:28];
		@(negedge clk);
		cmp({9'h0, phaseOut, cycleDone, acc, flagN, flagZ},
			{9'h0, PH_WR, 1'b1, eAcc, eN, eZ});
		cmp({mem.wrEn, 1'b0, mem.wrEn ? {mem.addr, mem.wdata} : 20'h0}, eW);
		cmp({10'h0, ptr.wrHigh, ptr.wrLow, (ptr.wrHigh | ptr.wrLow) ?
			{ptr.sel, ptr.data} : 10'h0}, eP);
		eW = 0;
		eP = 0;
		a = w[A_BIT] ? {bankSel, w[7:0]} : {w[7] ? 4'hf : 4'h0, w[7:0]};
		if (pend[15:12] == OP_MOVFF1 && w[15:12] == OP_SECOND) begin
			r = pend[11:0] == ACC_ADDR ? eAcc : m[pend[11:0]];
			if (w[11:0] == ACC_ADDR) eAcc = r;
			else begin
				m[w[11:0]] = r;
				eW = {2'b10, w[11:0], r};
			end
		end else if (pend[15:10] == OP_LD_PTR && pend[9:8] != 2'h3)
			eP = {12'h1, pend[9:8], w[7:0]};
		else if (w[15:10] == OP_LD_PTR && w[9:8] != 2'h3)
			eP = {12'h2, w[9:8], 4'h0, w[3:0]};
		else if (w[15:8] == OP_OR_LIT || w[15:10] inside {OP_OR_FILE,
			OP_MOV_FILE}) begin
			r = w[15:10] == OP_MOV_FILE ? m[a] :
				eAcc | (w[15:8] == OP_OR_LIT ? w[7:0] : m[a]);
			eN = r[7];
			eZ = r == 8'h00;
			if (w[15:8] != OP_OR_LIT && w[D_BIT]) begin
				m[a] = r;
				eW = {2'b10, a, r};
			end else eAcc = r;
		end
		pend = (pend[15:12] == 4'hc || pend[15:10] == OP_LD_PTR) ? '0 : w;
	endtask
	initial begin
		#200us;
		n_errors++;
		close_out;
	end
	initial begin
		for (int i = 0; i < 4096; i++) m[i] = 8'(i * 37);
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		step(16'h0900);
		for (int i = 0; i < 400; i++) begin
			rng = xs(rng);
			case (rng[18:16])
				0: step({OP_OR_LIT, rng[7:0]});
				1: step({OP_OR_FILE, rng[9:0]});
				2: step({OP_MOV_FILE, rng[9:0]});
				3: begin
					step({OP_LD_PTR, rng[9:8], 4'h0, rng[3:0]});
					step({OP_LD_PTR2, rng[7:0]});
				end
				4: begin
					step({OP_MOVFF1, rng[20] ? ACC_ADDR : rng[11:0]});
					// Low destinations or the accumulator only
					step({OP_SECOND, rng[21] ? ACC_ADDR : {1'b0, rng[26:16]}});
				end
				5: step({OP_SECOND, rng[11:0]});
				default: step(16'h0000);
			endcase
		end
		step(16'h0000);
		close_out;
	end
endmodule // tb_or_load_move_instr_exec
